// ### hdl/ussu_regs.svh
// reset values, field positions and widths of the serial shift unit
`ifndef USSU_REGS_SVH
`define USSU_REGS_SVH
`define USSU_DATA_W 8
`define USSU_CNT_W 4
`define USSU_DR_RST 8'h00
`define USSU_CNT_RST 4'h0
`define USSU_SYNC_N 2
`define USSU_SY_SDI 0
`define USSU_SY_SCK 1
`define USSU_SY_W 2
`endif

// ### hdl/ussu_pkg.sv
// types of the serial shift unit
package ussu_pkg;
	typedef enum logic [1:0] {
		USSU_WM_NONE  = 2'b00,
		USSU_WM_THREE = 2'b01,
		USSU_WM_TWO   = 2'b10,
		USSU_WM_TWO_H = 2'b11
	} ussu_wire_e;

	typedef enum logic [1:0] {
		USSU_HOLD_IDLE  = 2'b00,
		USSU_HOLD_START = 2'b01,
		USSU_HOLD_OVF   = 2'b10
	} ussu_hold_e;
endpackage

// ### hdl/ussu_top.sv
// serial shift unit: shift data register, edge counter, pin clocking and two-wire hold
// Notes on behaviour
// - 8-bit shift data register, CPU read and write, no receive buffer.
// - MSB is serial output, routed to data-out or data pin by wire mode.
// - pin clock: output latch changes on the edge opposite to input sampling; internal clock: one cycle after the shift.
// - serial input always taken from the data input pin.
// - 4-bit counter, CPU read and write, overflow raises interrupt request.
// - shift register and counter clocked by one common selected source, unless count_toggle_sel clocks the counter from the toggle bit.
// - external pin clock: counter increments on both edges.
// - shift clock source: pin, timer compare match or software strobe.
// - two-wire: start flag request and clock held low after start, or after overflow in USSU_WM_TWO_H mode only.
// - three-wire mode works as SPI modes 0 and 1, no slave select.
// - two linked units exchange register contents after eight clocks.
// - overflow flag set on counter wrap marks byte completion.
// - writing the clock-toggle bit toggles the serial clock pin.
// - mode 0 samples on rise, shifts on fall; mode 1 the opposite.
// - sixteen counted edges overflow the counter; process data before next.
// - counter overflow interrupt can wake processor from idle.
// - counter may advance on each toggle strobe; sixteen writes make a byte.
// - data write in the same cycle as a shift keeps written value.
// - with wire mode zero, external data and clock inputs still work.
`timescale 1ns/1ps
`include "ussu_regs.svh"

module ussu_top #(
	parameter int DATA_W = `USSU_DATA_W,
	parameter int CNT_W  = `USSU_CNT_W
) (
	input  wire logic               sys_clk,
	input  wire logic               arst_n,
	// cpu side
	input  wire logic               data_wr,
	input  wire logic [DATA_W-1:0]  data_wdata,
	output logic      [DATA_W-1:0]  shift_data_reg,
	input  wire logic               count_wr,
	input  wire logic [CNT_W-1:0]   count_wdata,
	output logic      [CNT_W-1:0]   shift_count,
	input  wire ussu_pkg::ussu_wire_e wire_mode_field,
	input  wire logic               clock_source_select,
	input  wire logic               clock_edge_select,
	input  wire logic               count_toggle_sel,
	input  wire logic               clock_toggle_bit,
	input  wire logic               shift_strobe_bit,
	input  wire logic               timer_match,
	input  wire logic               ovf_flag_clr,
	input  wire logic               start_flag_clr,
	input  wire logic               ovf_int_en,
	input  wire logic               start_int_en,
	input  wire logic               data_out_dir,
	input  wire logic               clock_pin_dir,
	output logic                    counter_overflow_flag,
	output logic                    start_flag,
	output logic                    ovf_irq,
	output logic                    start_irq,
	// pins
	input  wire logic               serial_in_pin,
	input  wire logic               serial_clock_pin,
	output logic                    serial_clock_out,
	output logic                    serial_clock_oe,
	output logic                    data_out_pin,
	output logic                    data_out_oe,
	output logic                    data_line_out,
	output logic                    data_line_oe
);
	import ussu_pkg::*;

	generate
		if (DATA_W < 2 || CNT_W < 2) begin : g_bad_width
			$error("ussu_top: DATA_W and CNT_W must be at least 2");
		end
	endgenerate

	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	function automatic logic is_two_wire(input ussu_wire_e m);
		is_two_wire = (m == USSU_WM_TWO) || (m == USSU_WM_TWO_H);
	endfunction

	// ---------------- link domain: runs on the serial clock pin ----------------
	// each edge toggles a flag and captures the data input with it
	logic rise_tgl;
	logic rise_bit;
	logic fall_tgl;
	logic fall_bit;

	always_ff @(posedge serial_clock_pin or negedge arst_n) begin
		if (!arst_n) begin
			rise_tgl <= 1'b0;
			rise_bit <= 1'b0;
		end else begin
			rise_tgl <= ~rise_tgl;
			rise_bit <= serial_in_pin;
		end
	end

	always_ff @(negedge serial_clock_pin or negedge arst_n) begin
		if (!arst_n) begin
			fall_tgl <= 1'b0;
			fall_bit <= 1'b0;
		end else begin
			fall_tgl <= ~fall_tgl;
			fall_bit <= serial_in_pin;
		end
	end

	// ---------------- crossings into sys_clk ----------------
	logic [2:0] rise_sync;
	logic [2:0] fall_sync;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rise_sync <= 3'h0;
			fall_sync <= 3'h0;
		end else begin
			rise_sync <= {rise_sync[1:0], rise_tgl};
			fall_sync <= {fall_sync[1:0], fall_tgl};
		end
	end

	logic rise_ev;
	logic fall_ev;
	assign rise_ev = rise_sync[2] ^ rise_sync[1];
	assign fall_ev = fall_sync[2] ^ fall_sync[1];

	// pin levels for the start detector and internal-clock data
	logic [`USSU_SY_W-1:0] pin_raw;
	logic [`USSU_SY_W-1:0] pin_s;
	assign pin_raw[`USSU_SY_SDI] = serial_in_pin;
	assign pin_raw[`USSU_SY_SCK] = serial_clock_pin;

	genvar gi;
	generate
		for (gi = 0; gi < `USSU_SY_W; gi++) begin : g_sync
			logic [`USSU_SYNC_N-1:0] stage;
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					stage <= '0;
				end else begin
					stage <= {stage[`USSU_SYNC_N-2:0], pin_raw[gi]};
				end
			end
			assign pin_s[gi] = stage[`USSU_SYNC_N-1];
		end
	endgenerate

	logic sdi_s;
	logic scl_s;
	assign sdi_s = pin_s[`USSU_SY_SDI];
	assign scl_s = pin_s[`USSU_SY_SCK];

	// ---------------- clock selection ----------------
	logic samp_ev;
	logic samp_bit;
	logic out_ev;
	logic int_clk;
	logic int_clk_d;
	logic shift_ev;
	logic shift_in;
	logic latch_ev;
	logic cnt_ev;

	always_comb begin
		samp_ev  = clock_edge_select ? fall_ev : rise_ev;
		samp_bit = clock_edge_select ? fall_bit : rise_bit;
		out_ev   = clock_edge_select ? rise_ev : fall_ev;
		int_clk  = clock_edge_select ? timer_match : shift_strobe_bit;
		// pin clock regardless of wire mode
		shift_ev = clock_source_select ? samp_ev : int_clk;
		shift_in = clock_source_select ? samp_bit : sdi_s;
		latch_ev = clock_source_select ? out_ev : int_clk_d;
		if (count_toggle_sel) begin
			cnt_ev = clock_toggle_bit;
		end else if (clock_source_select) begin
			cnt_ev = rise_ev | fall_ev;
		end else begin
			cnt_ev = int_clk;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_clk_d <= 1'b0;
		end else begin
			int_clk_d <= int_clk;
		end
	end

	// ---------------- shift data register ----------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_data_reg <= `USSU_DR_RST;
		end else if (data_wr) begin
			shift_data_reg <= data_wdata;
		end else if (shift_ev) begin
			shift_data_reg <= {shift_data_reg[DATA_W-2:0], shift_in};
		end
	end

	// output latch: open on a data write, else follows msb on the output edge
	logic out_latch;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_latch <= 1'b0;
		end else if (data_wr) begin
			out_latch <= data_wdata[DATA_W-1];
		end else if (latch_ev) begin
			out_latch <= shift_data_reg[DATA_W-1];
		end
	end

	// ---------------- edge counter and overflow flag ----------------
	logic ovf_set;
	assign ovf_set = cnt_ev && !count_wr && (shift_count == CNT_MAX);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_count <= `USSU_CNT_RST;
		end else if (count_wr) begin
			shift_count <= count_wdata;
		end else if (cnt_ev) begin
			shift_count <= shift_count + CNT_ONE;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			counter_overflow_flag <= 1'b0;
		end else if (ovf_set) begin
			counter_overflow_flag <= 1'b1;
		end else if (ovf_flag_clr) begin
			counter_overflow_flag <= 1'b0;
		end
	end

	// ---------------- two-wire start detector ----------------
	logic sdi_prev;
	logic start_set;
	assign start_set = is_two_wire(wire_mode_field) && scl_s && sdi_prev && !sdi_s;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sdi_prev <= 1'b1;
		end else begin
			sdi_prev <= sdi_s;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			start_flag <= 1'b0;
		end else if (start_set) begin
			start_flag <= 1'b1;
		end else if (start_flag_clr) begin
			start_flag <= 1'b0;
		end
	end

	// ---------------- clock hold (wait states) ----------------
	ussu_hold_e hold_st;
	ussu_hold_e next_hold_st;
	logic       scl_low_seen;

	always_comb begin
		next_hold_st = hold_st;
		case (hold_st)
			USSU_HOLD_IDLE: begin
				if (start_set) begin
					next_hold_st = USSU_HOLD_START;
				end else if (ovf_set && wire_mode_field == USSU_WM_TWO_H) begin
					next_hold_st = USSU_HOLD_OVF;
				end
			end
			USSU_HOLD_START: begin
				if (start_flag_clr && !start_set) begin
					next_hold_st = USSU_HOLD_IDLE;
				end
			end
			USSU_HOLD_OVF: begin
				if (ovf_flag_clr && !ovf_set) begin
					next_hold_st = USSU_HOLD_IDLE;
				end
			end
			default: next_hold_st = USSU_HOLD_IDLE;
		endcase
		if (!is_two_wire(wire_mode_field)) begin
			next_hold_st = USSU_HOLD_IDLE;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_st <= USSU_HOLD_IDLE;
		end else begin
			hold_st <= next_hold_st;
		end
	end

	// after a start the line is held only once the master has pulled it low
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_low_seen <= 1'b0;
		end else if (hold_st != USSU_HOLD_START) begin
			scl_low_seen <= 1'b0;
		end else if (!scl_s) begin
			scl_low_seen <= 1'b1;
		end
	end

	logic hold_low;
	assign hold_low = (hold_st == USSU_HOLD_OVF)
		|| (hold_st == USSU_HOLD_START && scl_low_seen);

	// ---------------- serial clock output ----------------
	logic sck_state;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_state <= 1'b0;
		end else if (clock_toggle_bit) begin
			sck_state <= ~sck_state;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			serial_clock_out <= 1'b0;
			serial_clock_oe  <= 1'b0;
		end else if (is_two_wire(wire_mode_field)) begin
			// open drain: only ever pulls low
			serial_clock_out <= 1'b0;
			serial_clock_oe  <= hold_low || (clock_pin_dir && !sck_state);
		end else begin
			serial_clock_out <= sck_state;
			serial_clock_oe  <= clock_pin_dir;
		end
	end

	// ---------------- data outputs ----------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out_pin  <= 1'b0;
			data_out_oe   <= 1'b0;
			data_line_out <= 1'b0;
			data_line_oe  <= 1'b0;
		end else begin
			data_out_pin  <= out_latch;
			data_out_oe   <= (wire_mode_field == USSU_WM_THREE) && data_out_dir;
			data_line_out <= 1'b0;
			data_line_oe  <= is_two_wire(wire_mode_field) && data_out_dir
				&& !out_latch;
		end
	end

	// ---------------- interrupt requests ----------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_irq   <= 1'b0;
			start_irq <= 1'b0;
		end else begin
			ovf_irq   <= counter_overflow_flag && ovf_int_en;
			start_irq <= start_flag && start_int_en;
		end
	end

endmodule

// ### bench/ussu_asserts.sv
// port assertions of the serial shift unit
`timescale 1ns/1ps
module ussu_asserts #(
	parameter int DATA_W = 8,
	parameter int CNT_W  = 4
) (
	input wire logic                 sys_clk,
	input wire logic                 arst_n,
	input wire logic                 data_wr,
	input wire logic [DATA_W-1:0]    data_wdata,
	input wire logic [DATA_W-1:0]    shift_data_reg,
	input wire logic                 count_wr,
	input wire logic [CNT_W-1:0]     count_wdata,
	input wire logic [CNT_W-1:0]     shift_count,
	input wire ussu_pkg::ussu_wire_e wire_mode_field,
	input wire logic                 clock_source_select,
	input wire logic                 clock_edge_select,
	input wire logic                 count_toggle_sel,
	input wire logic                 clock_toggle_bit,
	input wire logic                 shift_strobe_bit,
	input wire logic                 timer_match,
	input wire logic                 ovf_flag_clr,
	input wire logic                 ovf_int_en,
	input wire logic                 counter_overflow_flag,
	input wire logic                 ovf_irq,
	input wire logic                 serial_clock_out,
	input wire logic                 data_out_pin,
	input wire logic                 data_out_oe
);
	import ussu_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic sw_step;
	assign sw_step = !clock_source_select && !clock_edge_select && shift_strobe_bit;
	a_write_loads_data: assert property (data_wr |=> shift_data_reg == $past(data_wdata))
		else $error("data write lost");
	a_count_write: assert property (count_wr |=> shift_count == $past(count_wdata))
		else $error("count write lost");
	a_strobe_counts: assert property (sw_step && !count_toggle_sel && !count_wr
		|=> shift_count == CNT_W'($past(shift_count) + 1'b1)) else $error("strobe not counted");
	a_strobe_shifts: assert property (sw_step && !data_wr
		|=> shift_data_reg[DATA_W-1:1] == $past(shift_data_reg[DATA_W-2:0]))
		else $error("strobe not shifted");
	a_wrap_sets_flag: assert property (!count_wr && shift_count == {CNT_W{1'b1}}
		##1 shift_count == '0 |-> ##[0:1] counter_overflow_flag) else $error("wrap without flag");
	a_clear_flag: assert property (ovf_flag_clr && shift_count != {CNT_W{1'b1}}
		|=> !counter_overflow_flag) else $error("flag not cleared");
	a_msb_drives_out: assert property (data_wr && wire_mode_field == USSU_WM_THREE
		##1 !sw_step && !clock_source_select && !timer_match
		|=> data_out_pin == $past(data_wdata[DATA_W-1], 2)) else $error("msb not on pin");
	a_oe_off_mode: assert property (wire_mode_field != USSU_WM_THREE |=> !data_out_oe)
		else $error("data out driven");
	a_toggle_flips: assert property (clock_toggle_bit && wire_mode_field == USSU_WM_THREE
		##1 !clock_toggle_bit |=> serial_clock_out != $past(serial_clock_out))
		else $error("clock pin not toggled");
	a_irq_follows: assert property (counter_overflow_flag && ovf_int_en |=> ovf_irq)
		else $error("irq missing");
	cover property (counter_overflow_flag && ovf_irq);
	cover property (data_wr && shift_strobe_bit);
	cover property (clock_source_select && shift_count == {CNT_W{1'b1}});
endmodule
bind ussu_top ussu_asserts #(.DATA_W(DATA_W), .CNT_W(CNT_W)) i_ussu_asserts (.sys_clk, .arst_n,
	.data_wr, .data_wdata, .shift_data_reg, .count_wr, .count_wdata, .shift_count,
	.wire_mode_field, .clock_source_select, .clock_edge_select, .count_toggle_sel,
	.clock_toggle_bit, .shift_strobe_bit, .timer_match, .ovf_flag_clr, .ovf_int_en,
	.counter_overflow_flag, .ovf_irq, .serial_clock_out, .data_out_pin, .data_out_oe);

// ### bench/ussu_spi_peer.sv
// far-side master model: one byte exchange in mode 0 or 1 over the pin clock
`timescale 1ns/1ps
module ussu_spi_peer #(
	parameter int HALF = 20
) (
	input  wire logic       link_clk,
	input  wire logic       go,
	input  wire logic       mode,
	input  wire logic [7:0] tx,
	input  wire logic       miso,
	output logic            sck,
	output logic            mosi,
	output logic [7:0]      rx,
	output logic            done
);
	logic [7:0] sh;
	initial begin
		sck = 0;
		mosi = 1;
		rx = 0;
		done = 1;
	end
	always @(posedge go) begin
		done = 0;
		sh = tx;
		if (!mode) begin
			mosi = sh[7];
			sh = sh << 1;
		end
		repeat (HALF) @(posedge link_clk);
		for (int i = 0; i < 16; i++) begin
			sck = ~sck;
			if (i[0] == mode)
				rx = {rx[6:0], miso};
			else begin
				mosi = sh[7];
				sh = sh << 1;
			end
			repeat (HALF) @(posedge link_clk);
		end
		mosi = ~mosi;
		done = 1;
	end
endmodule

// ### bench/testbench.sv
// self-checking bench of the serial shift unit
`timescale 1ns/1ps
module testbench;
	import ussu_pkg::*;
	logic sys_clk = 0, arst_n = 0, link_clk = 0, sdi = 0, use_peer = 0, go = 0;
	logic data_wr = 0, count_wr = 0, clock_source_select = 0, clock_edge_select = 0;
	logic count_toggle_sel = 0, clock_toggle_bit = 0, shift_strobe_bit = 0, timer_match = 0;
	logic ovf_flag_clr = 0, ovf_int_en = 0, data_out_dir = 0, scl = 0;
	logic start_flag_clr = 0, start_int_en = 0, clock_pin_dir = 0;
	logic [7:0] data_wdata = 0, ptx = 0, dtx = 0;
	logic [3:0] count_wdata = 0;
	ussu_wire_e wire_mode_field = USSU_WM_THREE;
	wire [7:0] shift_data_reg, prx;
	wire [3:0] shift_count;
	wire counter_overflow_flag, ovf_irq, data_out_pin, psck, pmosi, pdone;
	wire start_flag, start_irq, serial_clock_out, serial_clock_oe, data_out_oe;
	wire data_line_out, data_line_oe;
	int n_fail = 0, samples_checked = 0;
	always #12.5 sys_clk = ~sys_clk;
	initial #3 forever #6 link_clk = ~link_clk;
	ussu_top i_ussu_top (.sys_clk, .arst_n, .data_wr, .data_wdata, .shift_data_reg, .count_wr,
		.count_wdata, .shift_count, .wire_mode_field, .clock_source_select, .clock_edge_select,
		.count_toggle_sel, .clock_toggle_bit, .shift_strobe_bit, .timer_match, .ovf_flag_clr,
		.start_flag_clr, .ovf_int_en, .start_int_en, .data_out_dir,
		.clock_pin_dir, .counter_overflow_flag, .start_flag, .ovf_irq, .start_irq,
		.serial_in_pin(use_peer ? pmosi : sdi), .serial_clock_pin(use_peer ? psck : scl),
		.serial_clock_out, .serial_clock_oe, .data_out_pin, .data_out_oe, .data_line_out,
		.data_line_oe);
	ussu_spi_peer i_ussu_spi_peer (.link_clk, .go, .mode(clock_edge_select), .tx(ptx),
		.miso(data_out_pin), .sck(psck), .mosi(pmosi), .rx(prx), .done(pdone));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge sys_clk);
		data_wr <= 1;
		data_wdata <= d;
		count_wr <= 1;
		count_wdata <= 4'h0;
		ovf_flag_clr <= 1;
		@(posedge sys_clk);
		data_wr <= 0;
		count_wr <= 0;
		ovf_flag_clr <= 0;
	endtask
	task automatic pulse(input logic t, input logic s, input logic m);
		clock_toggle_bit <= t;
		shift_strobe_bit <= s;
		timer_match <= m;
		@(posedge sys_clk);
		clock_toggle_bit <= 0;
		shift_strobe_bit <= 0;
		timer_match <= 0;
	endtask
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		end_of_test();
	end
	initial begin
		cyc(3);
		arst_n <= 1;
		cyc(2);
		#1 chk(shift_data_reg, 8'h00);
		chk(shift_count, 4'h0);
		data_out_dir <= 1;
		clock_pin_dir <= 1;
		ovf_int_en <= 1;
		count_toggle_sel <= 1;
		wr(8'hA5);
		#1 chk(shift_data_reg, 8'hA5);
		cyc(1);
		#1 chk(data_out_pin, 1'b1);
		chk(serial_clock_oe, 1'b1);
		$display("test write done");
		for (int i = 0; i < 16; i++) begin
			sdi <= 1'(8'h3C >> (7 - i / 2));
			cyc(4);
			pulse(1, i[0], 0);
		end
		cyc(3);
		#1 chk(shift_data_reg, 8'h3C);
		chk(shift_count, 4'h0);
		chk(counter_overflow_flag, 1'b1);
		chk(ovf_irq, 1'b1);
		$display("test toggle master done");
		count_toggle_sel <= 0;
		clock_pin_dir <= 0;
		clock_edge_select <= 1;
		wr(8'h00);
		sdi <= 1;
		repeat (3) begin
			cyc(3);
			pulse(0, 0, 1);
		end
		cyc(3);
		#1 chk(shift_data_reg, 8'h07);
		chk(shift_count, 4'h3);
		chk(counter_overflow_flag, 1'b0);
		@(posedge sys_clk);
		clock_edge_select <= 0;
		cyc(2);
		data_wr <= 1;
		data_wdata <= 8'h81;
		shift_strobe_bit <= 1;
		@(posedge sys_clk);
		data_wr <= 0;
		shift_strobe_bit <= 0;
		#1 chk(shift_data_reg, 8'h81);
		$display("test timer and collision done");
		use_peer <= 1;
		clock_source_select <= 1;
		for (int k = 0; k < 3; k++) begin
			wire_mode_field <= (k == 2) ? USSU_WM_NONE : USSU_WM_THREE;
			clock_edge_select <= k[0];
			ptx <= 8'h5A + 8'(k);
			dtx = 8'hC3 ^ 8'(k);
			wr(dtx);
			cyc(4);
			go <= 1;
			cyc(1);
			go <= 0;
			for (int j = 0; j < 400 && pdone !== 1'b1; j++)
				cyc(1);
			cyc(10);
			#1 chk(shift_data_reg, ptx);
			if (k < 2)
				chk(prx, dtx);
			chk(shift_count, 4'h0);
			chk(counter_overflow_flag, 1'b1);
			chk(data_out_oe, k < 2);
			chk(pdone, 1'b1);
			$display("test pin exchange %0d done", k);
		end
		use_peer <= 0;
		clock_source_select <= 0;
		sdi <= 1;
		scl <= 1;
		start_int_en <= 1;
		cyc(4);
		wire_mode_field <= USSU_WM_TWO_H;
		wr(8'h00);
		cyc(3);
		#1 chk(start_flag, 1'b0);
		chk(data_line_oe, 1'b1);
		chk(data_line_out, 1'b0);
		chk(data_out_oe, 1'b0);
		sdi <= 0;
		cyc(5);
		#1 chk(start_flag, 1'b1);
		chk(start_irq, 1'b1);
		chk(serial_clock_oe, 1'b0);
		scl <= 0;
		cyc(5);
		#1 chk(serial_clock_oe, 1'b1);
		chk(serial_clock_out, 1'b0);
		start_flag_clr <= 1;
		cyc(1);
		start_flag_clr <= 0;
		cyc(3);
		#1 chk(start_flag, 1'b0);
		chk(serial_clock_oe, 1'b0);
		count_wr <= 1;
		count_wdata <= 4'hF;
		cyc(1);
		count_wr <= 0;
		pulse(0, 1, 0);
		cyc(3);
		#1 chk(counter_overflow_flag, 1'b1);
		chk(serial_clock_oe, 1'b1);
		ovf_flag_clr <= 1;
		cyc(1);
		ovf_flag_clr <= 0;
		cyc(3);
		#1 chk(serial_clock_oe, 1'b0);
		$display("test two-wire hold done");
		end_of_test();
	end
endmodule
